// ### hdl/sdc_params.svh
// Constants for the card-side SD bus front end
`ifndef SDC_PARAMS_SVH
`define SDC_PARAMS_SVH

// ----------------------------------------
// Command indices
// ----------------------------------------
`define SDC_CMD_GO_IDLE 6'h00
`define SDC_CMD_ALL_CID 6'h02
`define SDC_CMD_REL_ADDR 6'h03
`define SDC_CMD_SELECT 6'h07
`define SDC_CMD_SEND_CSD 6'h09
`define SDC_CMD_SEND_CID 6'h0a
`define SDC_CMD_APP 6'h37
`define SDC_ACMD_WIDTH 6'h06
`define SDC_ACMD_STATUS 6'h0d
`define SDC_ACMD_OP_COND 6'h29
`define SDC_ACMD_CARD_DET 6'h2a

// ----------------------------------------
// Field values and timing
// ----------------------------------------
`define SDC_OCR_VOLT 32'h00ff8000
`define SDC_OCR_READY_BIT 31
`define SDC_WIDTH_FOUR 2'h2
`define SDC_NCR 3'h2
`define SDC_LEN_SHORT 8'h30
`define SDC_LEN_LONG 8'h88
`define SDC_LEN_SPI 8'h08
`define SDC_RCA_SEED 16'h0001

`endif

// ### hdl/sdc_pkg.sv
// Types and shared helpers for the card-side SD bus front end
`default_nettype none
package sdc_pkg;

   typedef enum logic [4:0] {
      SDC_IDLE = 5'h01,
      SDC_READY = 5'h02,
      SDC_IDENT = 5'h04,
      SDC_STBY = 5'h08,
      SDC_TRAN = 5'h10
   } sdc_state_e;

   // CRC7 over the first 40 bits of a command or short response
   function automatic logic [6:0] sdc_crc7(input logic [39:0] d);
      logic [6:0] c;
      logic fb;
      c = 7'h00;
      for (int i = 39; i >= 0; i--) begin
         fb = d[i] ^ c[6];
         c = {c[5:0], 1'b0};
         if (fb) begin
            c = c ^ 7'h09;
         end
      end
      return c;
   endfunction

endpackage
`default_nettype wire

// ### hdl/sdc_rx_if.sv
// Link between the card core and its command receiver
`default_nettype none
interface sdc_rx_if;
   logic bit_in;
   logic rise;
   logic listen;
   logic crc_on;
   logic valid;
   logic [5:0] index;
   logic [31:0] arg;
   modport core (output bit_in, rise, listen, crc_on, input valid, index, arg);
   modport rx (input bit_in, rise, listen, crc_on, output valid, index, arg);
endinterface
`default_nettype wire

// ### hdl/sdc_cmd_rx.sv
// Serial command frame receiver for the CMD line
`include "sdc_params.svh"
`default_nettype none
module sdc_cmd_rx (
   input wire logic ref_clk,
   input wire logic rstn,
   sdc_rx_if.rx rx
);
   import sdc_pkg::*;

   logic [47:0] sr_reg;
   logic [5:0] cnt_reg;
   logic valid_reg;

   wire [47:0] sr_next = {sr_reg[46:0], rx.bit_in};
   wire start_seen = rx.listen && rx.rise && cnt_reg == 6'h00 && !rx.bit_in;
   wire frame_end = rx.listen && rx.rise && cnt_reg == 6'h01;
   // SPI hosts normally leave CRC off, so the check is mode dependent
   wire crc_ok = !rx.crc_on || sdc_crc7(sr_next[47:8]) == sr_next[7:1];
   wire frame_ok = sr_next[46] && sr_next[0] && crc_ok; // [RULE_08]

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         sr_reg <= 48'h0;
         cnt_reg <= 6'h00;
         valid_reg <= 1'b0;
      end else begin
         valid_reg <= frame_end && frame_ok;
         if (!rx.listen) begin
            cnt_reg <= 6'h00;
         end else if (start_seen) begin
            cnt_reg <= 6'h2f;
            sr_reg <= sr_next;
         end else if (rx.rise && cnt_reg != 6'h00) begin
            cnt_reg <= cnt_reg - 6'h01;
            sr_reg <= sr_next;
         end
      end
   end

   assign rx.valid = valid_reg;
   assign rx.index = sr_reg[45:40];
   assign rx.arg = sr_reg[39:8];

   a_frame_bounds: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE_08]
      valid_reg |-> !sr_reg[47] && sr_reg[0])
      else $error("command accepted without start and stop bits");

endmodule
`default_nettype wire

// ### hdl/sdc_card.sv
// Card-side SD bus front end: mode select, identification, bus width
// Functional notes
// RULE_01: DAT1-3 stay inputs until four-bit width
// RULE_02: DAT3 pull-up enabled at power-up
// RULE_03: Host picks SPI by DAT3 low at CMD0
// RULE_04: ACMD42 disconnects the DAT3 pull-up
// RULE_05: Data width is one or four lines
// RULE_06: Default DAT0 only; width changes after init
// RULE_07: Host gives each card own CMD/DAT lines
// RULE_08: Frames open with start, close with stop
// RULE_09: Host sends commands serially on CMD
// RULE_10: Card responds on CMD only to commands
// RULE_11: Host gives over 74 idle clocks first
// RULE_12: Mode kept until CMD0 or power-up
// RULE_13: Host polls ACMD41 until OCR ready
// RULE_14: No ACMD41 answer means not a card
// RULE_15: CMD2 answered with 128-bit identification
// RULE_16: CMD3 returns new nonzero relative address
// RULE_17: CMD7 toggles standby and transfer states
// RULE_18: Host checks card type via ACMD13
// RULE_19: Standby answers CMD9 with CSD, CMD10 CID
// RULE_20: Host sets width with ACMD6 in transfer
// RULE_21: SPI: DAT3 select, CMD in, DAT0 out
// RULE_22: OCR bit 31 low until init done
// RULE_23: CMD0 resets state, address, width, mode
`include "sdc_params.svh"
`default_nettype none
module sdc_card #(
   parameter logic [127:0] CID_VALUE = 128'h0123_4567_89ab_cdef_0011_2233_4455_6601,
   parameter logic [127:0] CSD_VALUE = 128'h4000_0000_0000_0000_0000_0000_0000_0001,
   parameter logic [7:0] BUSY_POLLS = 8'h04
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic sd_clk,
   input wire logic cmd_in,
   output logic cmd_out,
   output logic cmd_oe,
   input wire logic [3:0] dat_in,
   output logic [3:0] dat_out,
   output logic [3:0] dat_oe,
   output logic dat3_pu_en,
   input wire logic dat_tx_en,
   input wire logic [3:0] dat_tx_nib,
   output logic spi_mode,
   output logic bus_wide,
   output logic card_ready,
   output sdc_pkg::sdc_state_e card_state
);
   import sdc_pkg::*;

   // ----------------------------------------
   // Pin synchronisers and clock edges
   // ----------------------------------------
   logic [1:0] clk_s_reg;
   logic clk_prev_reg;
   logic [1:0] cmd_s_reg;
   logic [1:0] dat3_s_reg;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         clk_s_reg <= 2'h0;
         clk_prev_reg <= 1'b0;
         cmd_s_reg <= 2'h3;
         dat3_s_reg <= 2'h3;
      end else begin
         clk_s_reg <= {clk_s_reg[0], sd_clk};
         clk_prev_reg <= clk_s_reg[1];
         cmd_s_reg <= {cmd_s_reg[0], cmd_in};
         dat3_s_reg <= {dat3_s_reg[0], dat_in[3]};
      end
   end

   wire clk_rise = clk_s_reg[1] && !clk_prev_reg;
   wire clk_fall = !clk_s_reg[1] && clk_prev_reg;
   wire dat3_sync = dat3_s_reg[1];

   // ----------------------------------------
   // Command receiver
   // ----------------------------------------
   sdc_state_e state_reg;
   sdc_state_e state_next;
   logic spi_mode_reg;
   logic bus_wide_reg;
   logic dat3_pu_en_reg;
   logic card_ready_reg;
   logic app_reg;
   logic [15:0] rca_reg;
   logic [15:0] lfsr_reg;
   logic [7:0] poll_reg;
   logic tx_busy_reg;
   sdc_rx_if rx_link ();

   assign rx_link.bit_in = cmd_s_reg[1];
   assign rx_link.rise = clk_rise;
   // In SPI the receiver only listens while chip select is low
   assign rx_link.listen = !tx_busy_reg && (!spi_mode_reg || !dat3_sync); // [RULE_21]
   assign rx_link.crc_on = !spi_mode_reg;

   sdc_cmd_rx u_rx (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .rx(rx_link)
   );

   // ----------------------------------------
   // Command decode
   // ----------------------------------------
   function automatic logic [3:0] state_code(input sdc_state_e s);
      case (s)
         SDC_IDLE: state_code = 4'h0;
         SDC_READY: state_code = 4'h1;
         SDC_IDENT: state_code = 4'h2;
         SDC_STBY: state_code = 4'h3;
         SDC_TRAN: state_code = 4'h4;
         default: state_code = 4'h0;
      endcase
   endfunction

   wire hit = rx_link.valid;
   wire [5:0] idx = rx_link.index;
   wire [31:0] arg = rx_link.arg;
   wire sd_hit = hit && !spi_mode_reg;
   wire is_cmd0 = hit && idx == `SDC_CMD_GO_IDLE;
   wire is_app = hit && !app_reg && idx == `SDC_CMD_APP;
   wire is_acmd41 = hit && app_reg && idx == `SDC_ACMD_OP_COND;
   wire is_cmd2 = sd_hit && !app_reg && idx == `SDC_CMD_ALL_CID;
   wire is_cmd3 = sd_hit && !app_reg && idx == `SDC_CMD_REL_ADDR;
   wire is_cmd7 = sd_hit && !app_reg && idx == `SDC_CMD_SELECT;
   wire is_cmd9 = sd_hit && !app_reg && idx == `SDC_CMD_SEND_CSD;
   wire is_cmd10 = sd_hit && !app_reg && idx == `SDC_CMD_SEND_CID;
   wire is_acmd6 = sd_hit && app_reg && idx == `SDC_ACMD_WIDTH;
   wire is_acmd13 = sd_hit && app_reg && idx == `SDC_ACMD_STATUS;
   wire is_acmd42 = sd_hit && app_reg && idx == `SDC_ACMD_CARD_DET;
   wire addr_match = arg[31:16] == rca_reg;
   wire in_stby = state_reg == SDC_STBY;
   wire in_tran = state_reg == SDC_TRAN;
   wire acmd6_wide = arg[1:0] == `SDC_WIDTH_FOUR;

   // Only a query with a voltage window advances power-up
   wire poll_step = is_acmd41 && arg[23:0] != 24'h0 && poll_reg != BUSY_POLLS;
   wire [7:0] poll_next = poll_step ? poll_reg + 8'h01 : poll_reg;
   wire init_done = poll_next == BUSY_POLLS; // [RULE_22]
   wire [31:0] ocr_w = `SDC_OCR_VOLT | ({31'h0, init_done} << `SDC_OCR_READY_BIT); // [RULE_22]

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         SDC_IDLE: if (is_acmd41 && init_done) state_next = SDC_READY;
         SDC_READY: if (is_cmd2) state_next = SDC_IDENT;
         SDC_IDENT: if (is_cmd3) state_next = SDC_STBY;
         SDC_STBY: if (is_cmd7 && addr_match) state_next = SDC_TRAN; // [RULE_17]
         SDC_TRAN: if (is_cmd7) state_next = SDC_STBY; // [RULE_17]
         default: state_next = SDC_IDLE;
      endcase
   end

   // ----------------------------------------
   // Response selection and framing
   // ----------------------------------------
   // A CMD0 that picks SPI is already answered in SPI form
   wire resp_spi = hit && (spi_mode_reg || (is_cmd0 && !dat3_sync)); // [RULE_21]
   wire resp_cid = (is_cmd2 && state_reg == SDC_READY) // [RULE_15]
      || (is_cmd10 && in_stby && addr_match); // [RULE_19]
   wire resp_csd = is_cmd9 && in_stby && addr_match; // [RULE_19]
   wire resp_r3 = is_acmd41 && !spi_mode_reg && state_reg inside {SDC_IDLE, SDC_READY};
   wire resp_r6 = is_cmd3 && state_reg inside {SDC_IDENT, SDC_STBY}; // [RULE_16]
   wire resp_r1 = (is_app && !spi_mode_reg) || (is_cmd7 && addr_match && (in_stby || in_tran))
      || (in_tran && (is_acmd42 || is_acmd6 || is_acmd13));
   wire resp_any = resp_spi || resp_cid || resp_csd || resp_r3 || resp_r6 || resp_r1; // [RULE_10]

   wire [31:0] status_w = {19'h0, state_code(state_reg), 1'b1, 2'h0, is_app, 5'h00};
   wire [31:0] r6_arg = {lfsr_reg, status_w[23:22], status_w[19], status_w[12:0]};
   wire [39:0] r1_body = {2'h0, idx, resp_r6 ? r6_arg : status_w};
   wire [135:0] f_r1 = {r1_body, sdc_crc7(r1_body), 1'b1, 88'h0};
   wire [135:0] f_r3 = {2'h0, 6'h3f, ocr_w, 7'h7f, 1'b1, 88'h0};
   wire [135:0] f_cid = {2'h0, 6'h3f, CID_VALUE[127:1], 1'b1};
   wire [135:0] f_csd = {2'h0, 6'h3f, CSD_VALUE[127:1], 1'b1};
   wire [135:0] f_spi = {7'h00, !init_done, 128'h0};
   wire [135:0] frame = resp_spi ? f_spi : resp_cid ? f_cid : resp_csd ? f_csd
      : resp_r3 ? f_r3 : f_r1;
   wire [7:0] frame_len = resp_spi ? `SDC_LEN_SPI
      : (resp_cid || resp_csd) ? `SDC_LEN_LONG : `SDC_LEN_SHORT;

   // ----------------------------------------
   // Card state
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= SDC_IDLE;
         spi_mode_reg <= 1'b0;
         bus_wide_reg <= 1'b0; // [RULE_06]
         dat3_pu_en_reg <= 1'b1; // [RULE_02]
         card_ready_reg <= 1'b0;
         app_reg <= 1'b0;
         rca_reg <= 16'h0;
         poll_reg <= 8'h00;
      end else if (is_cmd0) begin
         state_reg <= SDC_IDLE; // [RULE_23]
         card_ready_reg <= 1'b0;
         rca_reg <= 16'h0;
         bus_wide_reg <= 1'b0;
         app_reg <= 1'b0;
         poll_reg <= 8'h00;
         spi_mode_reg <= !dat3_sync; // [RULE_03] [RULE_12] [RULE_23]
      end else if (hit) begin
         state_reg <= state_next;
         card_ready_reg <= state_next != SDC_IDLE;
         app_reg <= is_app;
         poll_reg <= poll_next;
         if (resp_r6) rca_reg <= lfsr_reg; // [RULE_16]
         if (is_acmd42 && in_tran) dat3_pu_en_reg <= arg[0]; // [RULE_04]
         if (is_acmd6 && in_tran) bus_wide_reg <= acmd6_wide; // [RULE_05] [RULE_06]
      end
   end

   // Free-running, so the address depends on when the host asks
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         lfsr_reg <= `SDC_RCA_SEED;
      end else begin
         lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      end
   end

   // ----------------------------------------
   // Response shifter and pin drivers
   // ----------------------------------------
   logic [135:0] tx_sr_reg;
   logic [7:0] tx_cnt_reg;
   logic [2:0] tx_gap_reg;
   logic cmd_out_reg;
   logic cmd_oe_reg;
   logic [3:0] dat_out_reg;
   logic [3:0] dat_oe_reg;

   wire tx_load = hit && resp_any && !tx_busy_reg;
   wire tx_shift = tx_busy_reg && tx_gap_reg == 3'h0 && tx_cnt_reg != 8'h00;
   // Upper lines let go in the cycle the width narrows, not at the next link fall
   wire narrow_now = is_cmd0 || (is_acmd6 && in_tran && !acmd6_wide); // [RULE_01]
   wire [3:0] dat_oe_next = spi_mode_reg ? {3'h0, tx_shift} // [RULE_21]
      : {{3{dat_tx_en && bus_wide_reg}}, dat_tx_en}; // [RULE_01] [RULE_06]
   wire [3:0] dat_out_next = spi_mode_reg ? {3'h0, tx_sr_reg[135]}
      : bus_wide_reg ? dat_tx_nib : {3'h0, dat_tx_nib[0]};

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         tx_sr_reg <= 136'h0;
         tx_cnt_reg <= 8'h00;
         tx_gap_reg <= 3'h0;
         tx_busy_reg <= 1'b0;
      end else if (tx_load) begin
         tx_sr_reg <= frame;
         tx_cnt_reg <= frame_len;
         tx_gap_reg <= `SDC_NCR;
         tx_busy_reg <= 1'b1;
      end else if (tx_busy_reg && clk_fall) begin
         if (tx_gap_reg != 3'h0) begin
            tx_gap_reg <= tx_gap_reg - 3'h1;
         end else if (tx_cnt_reg != 8'h00) begin
            tx_sr_reg <= {tx_sr_reg[134:0], 1'b0};
            tx_cnt_reg <= tx_cnt_reg - 8'h01;
         end else begin
            tx_busy_reg <= 1'b0;
         end
      end
   end

   // Pins change on the falling link edge so the host samples on the rising one
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         cmd_out_reg <= 1'b1;
         cmd_oe_reg <= 1'b0;
         dat_out_reg <= 4'h0;
         dat_oe_reg <= 4'h0;
      end else if (clk_fall) begin
         cmd_oe_reg <= tx_shift && !spi_mode_reg; // [RULE_10] [RULE_21]
         cmd_out_reg <= tx_shift ? tx_sr_reg[135] : 1'b1;
         dat_oe_reg <= dat_oe_next & {{3{!narrow_now}}, 1'b1}; // [RULE_01]
         dat_out_reg <= dat_out_next;
      end else if (narrow_now) begin
         dat_oe_reg[3:1] <= 3'h0; // [RULE_01]
      end
   end

   assign cmd_out = cmd_out_reg;
   assign cmd_oe = cmd_oe_reg;
   assign dat_out = dat_out_reg;
   assign dat_oe = dat_oe_reg;
   assign dat3_pu_en = dat3_pu_en_reg;
   assign spi_mode = spi_mode_reg;
   assign bus_wide = bus_wide_reg;
   assign card_ready = card_ready_reg;
   assign card_state = state_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_pullup_clear: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE_04]
      is_acmd42 && in_tran && !arg[0] |=> !dat3_pu_en_reg)
      else $error("card detect pull-up not released");
   a_upper_lines: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE_01]
      dat_oe_reg[3:1] != 3'h0 |-> bus_wide_reg && !spi_mode_reg)
      else $error("upper data line driven while narrow");
   a_width_select: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE_05]
      is_acmd6 && in_tran |=> bus_wide_reg == $past(acmd6_wide))
      else $error("bus width not taken from command");
   a_reset_idle: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE_23]
      is_cmd0 |=> state_reg == SDC_IDLE && rca_reg == 16'h0 && !bus_wide_reg)
      else $error("reset command left state behind");
   a_mode_hold: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE_12]
      $changed(spi_mode_reg) |-> $past(is_cmd0))
      else $error("mode changed without reset command");
   a_addr_nonzero: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE_16]
      state_reg inside {SDC_STBY, SDC_TRAN} |-> rca_reg != 16'h0)
      else $error("relative address is zero");
   a_ocr_busy: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE_22]
      state_reg == SDC_READY |-> poll_reg == BUSY_POLLS)
      else $error("ready before power-up polls done");
   a_resp_start: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE_08]
      $rose(cmd_oe_reg) |-> !cmd_out_reg)
      else $error("response lacks start bit");
   a_resp_stop: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE_08]
      $fell(cmd_oe_reg) |-> $past(cmd_out_reg))
      else $error("response lacks stop bit");
   a_resp_cause: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE_10]
      $rose(tx_busy_reg) |-> $past(rx_link.valid))
      else $error("response without command");
   a_select_tran: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE_17]
      is_cmd7 && addr_match && in_stby |=> state_reg == SDC_TRAN ##[1:40] cmd_oe_reg)
      else $error("select did not reach transfer");
   a_spi_pins: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE_21]
      spi_mode_reg |-> !cmd_oe_reg && !dat_oe_reg[3])
      else $error("SPI mode drives an input pin");

endmodule
`default_nettype wire

// ### bench/sdc_host_model.sv
// Host-side model of the SD bus: link clock, command frames, response capture
`default_nettype none
module sdc_host_model (
   output logic sd_clk,
   output logic cmd_in,
   output logic [3:0] dat_in,
   input wire logic cmd_out,
   input wire logic cmd_oe,
   input wire logic [3:0] dat_out,
   input wire logic [3:0] dat_oe,
   input wire logic cs_low,
   input wire logic bad_crc
);
   timeunit 1ns;
   timeprecision 1ns;
   logic drv_en;
   logic drv_val;
   // ----------------------------------------
   // Pins: one card per bus, released lines sit at the pull-ups
   // ----------------------------------------
   assign cmd_in = cmd_oe ? cmd_out : (drv_en ? drv_val : 1'b1);
   assign dat_in[2:0] = (dat_oe[2:0] & dat_out[2:0]) | ~dat_oe[2:0];
   assign dat_in[3] = dat_oe[3] ? dat_out[3] : ~cs_low;
   initial begin
      sd_clk = 1'b0;
      drv_en = 1'b0;
      drv_val = 1'b1;
   end
   function automatic logic [6:0] crc7(input logic [39:0] d);
      logic [6:0] c;
      c = 7'h00;
      for (int i = 39; i >= 0; i--) begin
         c = {c[5:0], 1'b0} ^ (((d[i] ^ c[6]) == 1'b1) ? 7'h09 : 7'h00);
      end
      return c;
   endfunction
   // Card answers on falls, so the line is read just before each rise
   task automatic tick(output logic line, input logic spi);
      #400;
      line = spi ? dat_in[0] : cmd_in;
      sd_clk = 1'b1;
      #400;
      sd_clk = 1'b0;
   endtask
   task automatic idle(input int n);
      logic l;
      repeat (n) tick(l, 1'b0);
   endtask
   task automatic xfer(input logic [5:0] idx, input logic [31:0] arg, input int rlen,
                       input logic spi, output logic [135:0] resp, output logic got);
      logic [47:0] f;
      logic l;
      int n;
      f = {2'b01, idx, arg, crc7({2'b01, idx, arg}) ^ {6'h00, bad_crc}, 1'b1};
      resp = '0;
      got = 1'b0;
      n = 0;
      #137;
      drv_en = 1'b1;
      for (int i = 47; i >= 0; i--) begin
         drv_val = f[i];
         tick(l, spi);
      end
      drv_en = 1'b0;
      // No start bit within 64 periods means no answer at all
      while (!got && n < 64) begin
         tick(l, spi);
         got = (l === 1'b0);
         n++;
      end
      for (int i = 1; i < rlen && got; i++) begin
         tick(l, spi);
         resp = {resp[134:0], l};
      end
      idle(8);
   endtask
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the card-side SD bus front end
`include "sdc_params.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import sdc_pkg::*;
   localparam logic [127:0] CID_V = 128'h5a5a_0102_0304_0506_0708_090a_0b0c_0d01;
   localparam logic [127:0] CSD_V = 128'h400e_0032_5b59_0000_1d8f_7f80_0a40_0001;
   localparam int POLLS = 2;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic sd_clk, cmd_in, cmd_out, cmd_oe, dat3_pu_en, spi_mode, bus_wide, card_ready;
   logic [3:0] dat_in, dat_out, dat_oe;
   logic dat_tx_en = 1'b0;
   logic [3:0] dat_tx_nib = 4'h0;
   logic cs_low = 1'b0;
   logic bad_crc = 1'b0;
   logic spi_q = 1'b0;
   logic spi_cmd_drv = 1'b0;
   logic got;
   logic [135:0] resp;
   logic [15:0] rca = 16'h0000;
   sdc_state_e card_state;
   int error_cnt = 0;
   int samples_checked = 0;

   sdc_card #(.CID_VALUE(CID_V), .CSD_VALUE(CSD_V), .BUSY_POLLS(8'(POLLS))) dut (
      .ref_clk(ref_clk), .rstn(rstn), .sd_clk(sd_clk), .cmd_in(cmd_in), .cmd_out(cmd_out),
      .cmd_oe(cmd_oe), .dat_in(dat_in), .dat_out(dat_out), .dat_oe(dat_oe),
      .dat3_pu_en(dat3_pu_en), .dat_tx_en(dat_tx_en), .dat_tx_nib(dat_tx_nib),
      .spi_mode(spi_mode), .bus_wide(bus_wide), .card_ready(card_ready),
      .card_state(card_state));
   sdc_host_model host (.sd_clk(sd_clk), .cmd_in(cmd_in), .dat_in(dat_in), .cmd_out(cmd_out),
      .cmd_oe(cmd_oe), .dat_out(dat_out), .dat_oe(dat_oe), .cs_low(cs_low), .bad_crc(bad_crc));

   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (spi_mode === 1'b1 && cmd_oe === 1'b1) spi_cmd_drv <= 1'b1;

   // ----------------------------------------
   // Shared helpers
   // ----------------------------------------
   task automatic chk(input logic [135:0] a, input logic [135:0] e);
      samples_checked++;
      if (a !== e) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, a, e);
      end
   endtask
   task automatic cmd(input logic [5:0] idx, input logic [31:0] arg, input int rlen);
      host.xfer(idx, arg, rlen, spi_q, resp, got);
   endtask
   task automatic r1chk(input logic [5:0] idx);
      chk(136'({got, resp[47:40], resp[0]}), 136'({1'b1, 2'b00, idx, 1'b1}));
      chk(136'(resp[7:1]), 136'(host.crc7(resp[47:8])));
   endtask
   task automatic acmd(input logic [5:0] idx, input logic [31:0] arg, input int rlen);
      cmd(`SDC_CMD_APP, {rca, 16'h0000}, 48);
      r1chk(`SDC_CMD_APP);
      cmd(idx, arg, rlen);
   endtask
   task automatic do_reset();
      @(posedge ref_clk) #2;
      rstn = 1'b0;
      repeat (12) @(posedge ref_clk);
      #2;
      rstn = 1'b1;
      repeat (4) @(posedge ref_clk);
      #2;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      do_reset();
      // cmd_oe, cmd_out, dat_oe, pull-up, spi, wide, ready
      chk(136'({cmd_oe, cmd_out, dat_oe, dat3_pu_en, spi_mode, bus_wide, card_ready}), 136'(10'h108));
      chk(136'(card_state), 136'(SDC_IDLE));
      $display("t_reset done");
   endtask
   task automatic t_refused();
      host.idle(80);
      bad_crc = 1'b1;
      cmd(`SDC_CMD_APP, 32'h0, 48);
      chk(136'(got), 136'(0));
      bad_crc = 1'b0;
      cmd(`SDC_CMD_ALL_CID, 32'h0, 136);
      chk(136'({got, card_state}), 136'({1'b0, SDC_IDLE}));
      $display("t_refused done");
   endtask
   task automatic t_power_up();
      logic [31:0] ocr;
      cmd(`SDC_CMD_GO_IDLE, 32'h0, 48);
      chk(136'({got, spi_mode}), 136'(0));
      acmd(`SDC_ACMD_OP_COND, 32'h0, 48);
      chk(136'(resp[47:0]), 136'({8'h3f, `SDC_OCR_VOLT, 8'hff}));
      for (int p = 1; p <= POLLS; p++) begin
         acmd(`SDC_ACMD_OP_COND, `SDC_OCR_VOLT, 48);
         ocr = `SDC_OCR_VOLT | {p == POLLS, 31'h0};
         chk(136'(resp[47:0]), 136'({8'h3f, ocr, 8'hff}));
      end
      chk(136'({card_state, card_ready}), 136'({SDC_READY, 1'b1}));
      $display("t_power_up done");
   endtask
   task automatic t_ident();
      cmd(`SDC_CMD_ALL_CID, 32'h0, 136);
      chk(resp, {8'h3f, CID_V[127:1], 1'b1});
      cmd(`SDC_CMD_REL_ADDR, 32'h0, 48);
      r1chk(`SDC_CMD_REL_ADDR);
      rca = resp[39:24];
      chk(136'({rca != 16'h0, card_state}), 136'({1'b1, SDC_STBY}));
      $display("t_ident done");
   endtask
   task automatic t_standby();
      cmd(`SDC_CMD_SEND_CSD, {rca, 16'h0}, 136);
      chk(resp, {8'h3f, CSD_V[127:1], 1'b1});
      cmd(`SDC_CMD_SEND_CID, {rca, 16'h0}, 136);
      chk(resp, {8'h3f, CID_V[127:1], 1'b1});
      for (int k = 0; k < 3; k++) begin
         cmd(`SDC_CMD_SELECT, {rca, 16'h0}, 48);
         r1chk(`SDC_CMD_SELECT);
         chk(136'(card_state), 136'(k == 1 ? SDC_STBY : SDC_TRAN));
      end
      cmd(`SDC_CMD_SEND_CSD, {rca, 16'h0}, 136);
      chk(136'({got, card_state}), 136'({1'b0, SDC_TRAN}));
      $display("t_standby done");
   endtask
   task automatic t_width();
      acmd(`SDC_ACMD_STATUS, 32'h0, 48);
      r1chk(`SDC_ACMD_STATUS);
      acmd(`SDC_ACMD_WIDTH, 32'h2, 48);
      r1chk(`SDC_ACMD_WIDTH);
      @(posedge ref_clk) #2;
      dat_tx_en = 1'b1;
      dat_tx_nib = 4'ha;
      host.idle(2);
      chk(136'({bus_wide, dat_oe, dat_out}), 136'(9'h1fa));
      acmd(`SDC_ACMD_WIDTH, 32'h0, 48);
      chk(136'({bus_wide, dat_oe}), 136'(5'h01));
      acmd(`SDC_ACMD_CARD_DET, 32'h0, 48);
      chk(136'(dat3_pu_en), 136'(0));
      acmd(`SDC_ACMD_WIDTH, 32'h2, 48);
      @(posedge ref_clk) #2;
      dat_tx_en = 1'b0;
      cmd(`SDC_CMD_GO_IDLE, 32'h0, 48);
      chk(136'({spi_mode, bus_wide, dat_oe, card_state}), 136'({6'h00, SDC_IDLE}));
      $display("t_width done");
   endtask
   task automatic t_spi();
      do_reset();
      host.idle(80);
      cs_low = 1'b1;
      spi_q = 1'b1;
      cmd(`SDC_CMD_GO_IDLE, 32'h0, 8);
      chk(136'({got, resp[7:0], spi_mode}), 136'({1'b1, 8'h01, 1'b1}));
      cs_low = 1'b0;
      cmd(`SDC_CMD_GO_IDLE, 32'h0, 8);
      chk(136'({got, spi_mode, spi_cmd_drv}), 136'(3'b010));
      spi_q = 1'b0;
      do_reset();
      chk(136'(spi_mode), 136'(0));
      $display("t_spi done");
   endtask

   task automatic end_sim();
      $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      t_reset();
      t_refused();
      t_power_up();
      t_ident();
      t_standby();
      t_width();
      t_spi();
      end_sim();
   end
   // About 30 frames of roughly 100 us each, with wide margin
   initial begin
      #6_000_000;
      error_cnt++;
      end_sim();
   end
endmodule
`default_nettype wire
